//--- hdl/pfs_pkg.sv
/*
  pfs_pkg: offsets, field positions, reset values, timing counts and carrier
  types for the port fault and supply control register bank.
  assumes a single 10 MHz system clock.
*/
package pfs_pkg;
  localparam logic [7:0] ADDR_FAULT_CHANGE = 8'h12;
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h13;
  localparam logic [7:0] ADDR_CAPABILITY = 8'h18;
  localparam logic [7:0] ADDR_SWITCH_LIMIT = 8'h1e;
  localparam logic [7:0] ADDR_MONITOR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_WINDOW_CTRL = 8'h22;

  // fault status bit positions
  localparam int FLT_PULLUP_OV = 7;
  localparam int FLT_PULLUP_OK = 6;
  localparam int FLT_REV1 = 5;
  localparam int FLT_REV2 = 4;
  localparam int FLT_OC1 = 3;
  localparam int FLT_OC2 = 2;
  localparam int FLT_OV1 = 1;
  localparam int FLT_OV2 = 0;

  // fault change flag positions
  localparam int CHG_PULLUP_OV = 5;
  localparam int CHG_PULLUP_OK = 4;
  localparam int CHG_REV = 2;
  localparam int CHG_OC = 1;
  localparam int CHG_OV = 0;

  // capability register fields
  localparam int CAP_ADV_HI = 7;
  localparam int CAP_ADV_LO = 6;
  localparam int CAP_RSVD5 = 5;
  localparam int CAP_DISCHARGE = 4;
  localparam int CAP_SUPPLY = 0;
  localparam logic [7:0] CAP_RESET = 8'h21;
  localparam logic [1:0] ADV_DEFAULT = 2'h0;
  localparam logic [1:0] ADV_1A5 = 2'h1;
  localparam logic [1:0] ADV_3A0 = 2'h2;
  localparam logic [1:0] ADV_ILLEGAL = 2'h3;

  localparam logic [3:0] ILIM_RESET = 4'h0;
  localparam logic [3:0] ILIM_MAX = 4'h9;

  localparam int MON_ENABLE = 7;
  localparam int MON_LOW_LEVEL = 6;
  localparam logic [7:0] MON_RESET = 8'ha0;

  localparam logic [7:0] WINDOW_RESET = 8'h00;
  localparam logic [7:0] WINDOW_NVM_DEFAULT = 8'h00;

  // bus window: nominal +/-5 % of 5.0 V, in percent
  localparam int BUS_MILLIVOLT = 5000;
  localparam int NOMINAL_PCT = 5;

  localparam int CLK_HZ = 10_000_000;
  localparam int DISCHARGE_MS = 250;
  localparam int DISCHARGE_CYCLES = CLK_HZ / 1000 * DISCHARGE_MS;

  typedef struct packed {
    logic pullup_overvoltage_flag;
    logic pullup_supply_ok;
    logic conn_pwr_reverse_fault_line1;
    logic conn_pwr_reverse_fault_line2;
    logic conn_pwr_overcurrent_line1;
    logic conn_pwr_overcurrent_line2;
    logic conn_pwr_overvoltage_line1;
    logic conn_pwr_overvoltage_line2;
  } pfs_fault_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfs_req_t;

  typedef struct packed {
    logic [4:0] upper_pct;
    logic [4:0] lower_pct;
  } pfs_window_t;
endpackage

//--- hdl/pfs_regs.sv
/*
  pfs_regs: fault status, connector-power and bus-window control registers
  of a source port controller, with the fault change flags.
  assumes register requests arrive already decoded from the serial port as
  single-cycle read/write strobes, and comparator inputs are synchronous.
*/
// Function
// - status bit 7 shows pull-up overvoltage above 6.0 V
// - status bit 6 is 1 while pull-up supply is above 2.8 V
// - status bits 5,4 show reverse voltage on line1, line2 switches
// - status bits 3,2 show overcurrent on line1, line2 switches
// - status bits 1,0 show overvoltage per line; all reset to zero
// - advertised current 00 default, 01 1.5 A, 10 3.0 A; 11 unused
// - discharge enable bit 4 discharges connector power for 250 ms
// - capability bit 0 enables connector power, reset value one
// - four-bit switch current limit code, 0000 default, up to 1001
// - monitor bit 7 enables connector-power undervoltage detect, reset 1
// - detect disabled turns power path off and forces presence to 0
// - monitor bit 6 selects low undervoltage level when set
// - window bits 7:4 raise upper bus limit by value in percent
// - window bits 3:0 lower the lower bus limit by value in percent
// - unshifted window is plus and minus 5 percent of 5.0 V
// - while unattached the window register holds reset values
// - on attach window loads configuration; software may then overwrite
// - any fault bit change sets a change flag, cleared on read
`timescale 1ns/10ps
module pfs_regs #(
  parameter int DISCHARGE_CYCLES = pfs_pkg::DISCHARGE_CYCLES,
  parameter logic [7:0] WINDOW_NVM = pfs_pkg::WINDOW_NVM_DEFAULT
) (
  input wire logic clk, // system clock, 10 MHz
  input wire logic rst, // synchronous reset, active high
  input wire pfs_pkg::pfs_req_t req, // decoded register request
  input wire pfs_pkg::pfs_fault_t fault_in, // comparator levels
  input wire logic attached, // port attached level
  input wire logic conn_pwr_uv_ok, // connector power above uv level
  output pfs_pkg::pfs_fault_t fault_status, // fault status register
  output logic [7:0] rdata, // read data, one cycle after rd
  output logic rvalid, // read data valid pulse
  output logic [1:0] advertised_current_level, // advertised current
  output logic conn_pwr_supply_enable, // connector power path on
  output logic conn_pwr_discharge, // discharge active
  output logic [3:0] conn_pwr_current_limit, // switch current limit code
  output logic conn_pwr_undervolt_level_select, // 1 selects low level
  output logic conn_pwr_present, // connector power presence
  output logic [7:0] fault_change_flags, // change flags, pending
  output logic fault_alert, // any change flag pending
  output pfs_pkg::pfs_window_t bus_window // window limits in percent
);
  logic [7:0] cap;
  logic [7:0] mon;
  logic [7:0] window;
  logic attached_q;
  logic [$clog2(DISCHARGE_CYCLES+1)-1:0] dis_count;
  logic [7:0] next_change;
  logic [7:0] flt;
  logic [7:0] flt_in;
  logic uv_detect_en;

  function automatic logic wr_to(input pfs_pkg::pfs_req_t r,
                                 input logic [7:0] a);
    wr_to = r.wr && (r.addr == a);
  endfunction

  assign flt = fault_status;
  assign flt_in = fault_in;
  assign uv_detect_en = mon[pfs_pkg::MON_ENABLE];

  // comparators already synchronous; status follows them each clock
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_status <= '0;
    end else begin
      fault_status <= fault_in;
    end
  end

  // change flags: a new change wins over the clearing read
  always_comb begin
    next_change = fault_change_flags;
    if (req.rd && req.addr == pfs_pkg::ADDR_FAULT_CHANGE) begin
      next_change = '0;
    end
    if (flt_in[pfs_pkg::FLT_PULLUP_OV] != flt[pfs_pkg::FLT_PULLUP_OV]) begin
      next_change[pfs_pkg::CHG_PULLUP_OV] = 1'b1;
    end
    if (flt_in[pfs_pkg::FLT_PULLUP_OK] != flt[pfs_pkg::FLT_PULLUP_OK]) begin
      next_change[pfs_pkg::CHG_PULLUP_OK] = 1'b1;
    end
    if (flt_in[5:4] != flt[5:4]) begin
      next_change[pfs_pkg::CHG_REV] = 1'b1;
    end
    if (flt_in[3:2] != flt[3:2]) begin
      next_change[pfs_pkg::CHG_OC] = 1'b1;
    end
    if (flt_in[1:0] != flt[1:0]) begin
      next_change[pfs_pkg::CHG_OV] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_change_flags <= '0;
      fault_alert <= 1'b0;
    end else begin
      fault_change_flags <= next_change;
      fault_alert <= |next_change;
    end
  end

  // capability register; reserved bits keep their fixed values
  always_ff @(posedge clk) begin
    if (rst) begin
      cap <= pfs_pkg::CAP_RESET;
    end else if (wr_to(req, pfs_pkg::ADDR_CAPABILITY)) begin
      // the unused code is refused so the pins never advertise it
      if (req.wdata[7:6] != pfs_pkg::ADV_ILLEGAL) begin
        cap[7:6] <= req.wdata[7:6];
      end
      cap[pfs_pkg::CAP_DISCHARGE] <= req.wdata[pfs_pkg::CAP_DISCHARGE];
      cap[pfs_pkg::CAP_SUPPLY] <= req.wdata[pfs_pkg::CAP_SUPPLY];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conn_pwr_current_limit <= pfs_pkg::ILIM_RESET;
    end else if (wr_to(req, pfs_pkg::ADDR_SWITCH_LIMIT) &&
                 req.wdata[3:0] <= pfs_pkg::ILIM_MAX) begin
      conn_pwr_current_limit <= req.wdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mon <= pfs_pkg::MON_RESET;
    end else if (wr_to(req, pfs_pkg::ADDR_MONITOR_CTRL)) begin
      mon[7:6] <= req.wdata[7:6];
    end
  end

  // bus window: cleared while unattached, loaded on the attach edge
  always_ff @(posedge clk) begin
    if (rst) begin
      attached_q <= 1'b0;
      window <= pfs_pkg::WINDOW_RESET;
    end else begin
      attached_q <= attached;
      if (!attached) begin
        window <= pfs_pkg::WINDOW_RESET;
      end else if (!attached_q) begin
        window <= WINDOW_NVM;
      end else if (wr_to(req, pfs_pkg::ADDR_WINDOW_CTRL)) begin
        window <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_window <= '{upper_pct: 5'(pfs_pkg::NOMINAL_PCT),
                      lower_pct: 5'(pfs_pkg::NOMINAL_PCT)};
    end else begin
      bus_window.upper_pct <= 5'(pfs_pkg::NOMINAL_PCT) + {1'b0, window[7:4]};
      bus_window.lower_pct <= 5'(pfs_pkg::NOMINAL_PCT) + {1'b0, window[3:0]};
    end
  end

  // discharge runs a fixed time after the supply is turned off
  always_ff @(posedge clk) begin
    if (rst) begin
      dis_count <= '0;
      conn_pwr_discharge <= 1'b0;
    end else if (cap[pfs_pkg::CAP_DISCHARGE] && conn_pwr_supply_enable &&
                 !(cap[pfs_pkg::CAP_SUPPLY] && uv_detect_en)) begin
      dis_count <= ($bits(dis_count))'(DISCHARGE_CYCLES);
      conn_pwr_discharge <= 1'b1;
    end else if (dis_count > 1) begin
      dis_count <= dis_count - 1'b1;
    end else begin
      dis_count <= '0;
      conn_pwr_discharge <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conn_pwr_supply_enable <= 1'b0;
      conn_pwr_present <= 1'b0;
      advertised_current_level <= pfs_pkg::ADV_DEFAULT;
      conn_pwr_undervolt_level_select <= 1'b0;
    end else begin
      conn_pwr_supply_enable <= cap[pfs_pkg::CAP_SUPPLY] && uv_detect_en;
      conn_pwr_present <= uv_detect_en && conn_pwr_uv_ok;
      advertised_current_level <= cap[7:6];
      conn_pwr_undervolt_level_select <= mon[pfs_pkg::MON_LOW_LEVEL];
    end
  end

  // reads answer next cycle; only the change register clears on read
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        unique case (req.addr)
          pfs_pkg::ADDR_FAULT_CHANGE: rdata <= fault_change_flags;
          pfs_pkg::ADDR_FAULT_STATUS: rdata <= fault_status;
          pfs_pkg::ADDR_CAPABILITY: rdata <= cap;
          pfs_pkg::ADDR_SWITCH_LIMIT: rdata <= {4'h0, conn_pwr_current_limit};
          pfs_pkg::ADDR_MONITOR_CTRL: rdata <= mon;
          pfs_pkg::ADDR_WINDOW_CTRL: rdata <= window;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

//--- testbench/pfs_regs_monitor.sv
/*
  pfs_regs_monitor: concurrent checks on the register bank ports.
  assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/10ps
module pfs_regs_monitor #(
  parameter int DISCHARGE_CYCLES = 20
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire pfs_pkg::pfs_req_t req, // register request
  input wire pfs_pkg::pfs_fault_t fault_in, // comparator levels
  input wire logic attached, // attach level
  input wire pfs_pkg::pfs_fault_t fault_status, // status register
  input wire logic [7:0] rdata, // read data
  input wire logic rvalid, // read valid
  input wire logic [1:0] advertised_current_level, // advert level
  input wire logic conn_pwr_supply_enable, // power path on
  input wire logic conn_pwr_discharge, // discharge active
  input wire logic [3:0] conn_pwr_current_limit, // limit code
  input wire logic conn_pwr_present, // presence
  input wire logic fault_alert, // change pending
  input wire pfs_pkg::pfs_window_t bus_window // window limits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] dis_cnt;
  // length of the current discharge pulse, in clocks
  always_ff @(posedge clk) begin
    if (rst || !conn_pwr_discharge) dis_cnt <= 32'h0;
    else dis_cnt <= dis_cnt + 32'h1;
  end
  AST_FAULT_FOLLOW: assert property (
    !$past(rst) |-> fault_status == $past(fault_in))
    else $error("status lags input wrongly");
  // back-to-back reads keep rvalid high, so compare against the last strobe
  AST_RVALID: assert property (
    rvalid == $past(req.rd))
    else $error("read valid timing");
  AST_STATUS_READ: assert property (
    req.rd && req.addr == pfs_pkg::ADDR_FAULT_STATUS
    |=> rdata == $past(fault_status))
    else $error("status read data");
  AST_DISCHARGE_LEN: assert property (
    $fell(conn_pwr_discharge) |-> dis_cnt == DISCHARGE_CYCLES)
    else $error("discharge length");
  AST_ADV_LEGAL: assert property (
    advertised_current_level != pfs_pkg::ADV_ILLEGAL)
    else $error("illegal advert code");
  AST_LIMIT_WRITE: assert property (
    req.wr && req.addr == pfs_pkg::ADDR_SWITCH_LIMIT
    |=> conn_pwr_current_limit == (
      $past(req.wdata[3:0]) <= pfs_pkg::ILIM_MAX ?
      $past(req.wdata[3:0]) : $past(conn_pwr_current_limit)))
    else $error("limit write");
  // power outputs are registered from the control register: one more clock
  AST_DETECT_OFF: assert property (
    req.wr && req.addr == pfs_pkg::ADDR_MONITOR_CTRL && !req.wdata[7]
    |=> ##1 !conn_pwr_supply_enable && !conn_pwr_present)
    else $error("detect off keeps power");
  // window clears on the detach edge, the limits follow one clock later
  AST_WINDOW_UNATT: assert property (
    !$past(attached, 2) |-> bus_window == {5'h05, 5'h05})
    else $error("window not at reset");
  AST_CHANGE_ALERT: assert property (
    !$past(rst) && fault_status != $past(fault_status) |-> fault_alert)
    else $error("change not flagged");
  cover property (rvalid && rdata != 8'h00);
  cover property ($rose(conn_pwr_discharge));
  cover property ($rose(attached) ##3 bus_window != {5'h05, 5'h05});
endmodule
bind pfs_regs pfs_regs_monitor #(.DISCHARGE_CYCLES(DISCHARGE_CYCLES))
  pfs_watch (
  .clk(clk), .rst(rst), .req(req), .fault_in(fault_in), .attached(attached),
  .fault_status(fault_status), .rdata(rdata), .rvalid(rvalid),
  .advertised_current_level(advertised_current_level),
  .conn_pwr_supply_enable(conn_pwr_supply_enable),
  .conn_pwr_discharge(conn_pwr_discharge),
  .conn_pwr_current_limit(conn_pwr_current_limit),
  .conn_pwr_present(conn_pwr_present), .fault_alert(fault_alert),
  .bus_window(bus_window));

//--- testbench/tb.sv
/*
  tb: self-checking bench for pfs_regs; reads are scored from a queue.
  assumes the bound monitor and a shortened discharge count of 20.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb;
  logic clk = 1'b0, rst = 1'b1, attached = 1'b0, uv_ok = 1'b1;
  pfs_pkg::pfs_req_t req = '0;
  pfs_pkg::pfs_fault_t fin = '0, fst, old;
  logic [7:0] rdata, flags, chg, ev, exp_rd;
  logic rvalid, supply, dis, lvl, pres, alert;
  logic [1:0] adv, eadv;
  logic [3:0] lim, elim;
  pfs_pkg::pfs_window_t win;
  logic [31:0] seed = 32'h283f83ee;
  int miscompares = 0, samples_checked = 0, n;
  logic [7:0] expq[$];
  pfs_regs #(.DISCHARGE_CYCLES(20), .WINDOW_NVM(8'h47)) dut (.clk(clk),
    .rst(rst), .req(req), .fault_in(fin), .attached(attached),
    .conn_pwr_uv_ok(uv_ok), .fault_status(fst), .rdata(rdata),
    .rvalid(rvalid), .advertised_current_level(adv),
    .conn_pwr_supply_enable(supply), .conn_pwr_discharge(dis),
    .conn_pwr_current_limit(lim), .conn_pwr_undervolt_level_select(lvl),
    .conn_pwr_present(pres), .fault_change_flags(flags),
    .fault_alert(alert), .bus_window(win));
  initial begin
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk) req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    expq.push_back(e);
    @(negedge clk) req = '0;
  endtask
  // scorer: every read answer is matched with the oldest expectation;
  // it looks on the falling edge, where the registered answer has settled
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        `CHK(rvalid, 1'b0)
      end else begin
        exp_rd = expq.pop_front();
        `CHK(rdata, exp_rd)
      end
    end
  end
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rd(pfs_pkg::ADDR_FAULT_STATUS, 8'h00);
    rd(pfs_pkg::ADDR_CAPABILITY, pfs_pkg::CAP_RESET);
    rd(pfs_pkg::ADDR_MONITOR_CTRL, pfs_pkg::MON_RESET);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 12; i++) begin
      old = fin;
      @(negedge clk) fin = 8'(xs());
      ev = old ^ fin;
      chg = {2'b00, ev[7], ev[6], 1'b0, |ev[5:4], |ev[3:2], |ev[1:0]};
      wr(pfs_pkg::ADDR_FAULT_STATUS, 8'h5a);
      `CHK(fst, fin)
      `CHK(flags, chg)
      `CHK(alert, |chg)
      rd(pfs_pkg::ADDR_FAULT_CHANGE, chg);
      rd(pfs_pkg::ADDR_FAULT_STATUS, fin);
      rd(pfs_pkg::ADDR_FAULT_CHANGE, 8'h00);
    end
    $display("fault status test done");
    eadv = pfs_pkg::ADV_DEFAULT;
    for (int a = 0; a < 4; a++) begin
      wr(pfs_pkg::ADDR_CAPABILITY, {a[1:0], 6'h2f});
      if (a != 3) eadv = a[1:0];
      // the advert pins follow the register one clock after the write
      @(negedge clk);
      `CHK(adv, eadv)
      rd(pfs_pkg::ADDR_CAPABILITY, {eadv, 6'h21});
    end
    elim = pfs_pkg::ILIM_RESET;
    for (int v = 0; v < 11; v++) begin
      wr(pfs_pkg::ADDR_SWITCH_LIMIT, {4'hf, v[3:0]});
      if (v <= 9) elim = v[3:0];
      `CHK(lim, elim)
      rd(pfs_pkg::ADDR_SWITCH_LIMIT, {4'h0, elim});
    end
    $display("capability and limit test done");
    wr(pfs_pkg::ADDR_MONITOR_CTRL, 8'he0);
    // control outputs are registered from the register: one more clock
    @(negedge clk);
    `CHK(lvl, 1'b1)
    wr(pfs_pkg::ADDR_CAPABILITY, 8'h31);
    @(negedge clk);
    `CHK(supply, 1'b1)
    `CHK(adv, pfs_pkg::ADV_DEFAULT)
    wr(pfs_pkg::ADDR_MONITOR_CTRL, 8'h20);
    @(negedge clk);
    `CHK(supply, 1'b0)
    `CHK(pres, 1'b0)
    n = 0;
    // bounded: a discharge that never ends is a fault, not a hang
    while (dis === 1'b1 && n < 100) @(negedge clk) n++;
    `CHK(n, 20)
    wr(pfs_pkg::ADDR_MONITOR_CTRL, 8'ha0);
    @(negedge clk);
    `CHK(supply, 1'b1)
    `CHK(pres, 1'b1)
    uv_ok = 1'b0;
    @(negedge clk);
    `CHK(pres, 1'b0)
    uv_ok = 1'b1;
    wr(pfs_pkg::ADDR_CAPABILITY, 8'h20);
    repeat (30) @(negedge clk);
    `CHK(dis, 1'b0)
    `CHK(supply, 1'b0)
    $display("monitor and discharge test done");
    wr(pfs_pkg::ADDR_WINDOW_CTRL, 8'h3a);
    `CHK(win, 10'h0a5)
    rd(pfs_pkg::ADDR_WINDOW_CTRL, 8'h00);
    attached = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(win, {5'h09, 5'h0c})
    rd(pfs_pkg::ADDR_WINDOW_CTRL, 8'h47);
    wr(pfs_pkg::ADDR_WINDOW_CTRL, 8'hf1);
    @(negedge clk);
    `CHK(win, {5'h14, 5'h06})
    rd(pfs_pkg::ADDR_WINDOW_CTRL, 8'hf1);
    attached = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(win, {5'h05, 5'h05})
    rd(pfs_pkg::ADDR_WINDOW_CTRL, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(expq.size(), 0)
    $display("window test done");
    report_and_stop();
  end
endmodule
